// ==== hdl/wct_pkg.sv ====
// Shared constants, codes and timer tables for the wake input and cyclic timer block
package wct_pkg;

    // System clock: 20 MHz, 50 ns period
    localparam int CLK_MHZ = 20;

    // Static filter times and the timer tick, in microseconds
    localparam int FILT_A_US = 16;
    localparam int FILT_B_US = 64;
    localparam int TICK_US = 100;
    localparam logic [10:0] FILT_A_CYC = 11'(FILT_A_US * CLK_MHZ);
    localparam logic [10:0] FILT_B_CYC = 11'(FILT_B_US * CLK_MHZ);
    localparam logic [10:0] TICK_CYC = 11'(TICK_US * CLK_MHZ);

    // On-times in microseconds, periods in milliseconds
    localparam int ON_T1_US = 100;
    localparam int ON_T2_US = 300;
    localparam int ON_T3_US = 1000;
    localparam int ON_T4_US = 10000;
    localparam int ON_T5_US = 20000;
    localparam int PER_T0_MS = 10;
    localparam int PER_T1_MS = 20;
    localparam int PER_T2_MS = 50;
    localparam int PER_T3_MS = 100;
    localparam int PER_T4_MS = 200;
    localparam int PER_T5_MS = 1000;
    localparam int PER_T6_MS = 2000;

    // Serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 7;

    // Register addresses
    localparam logic [6:0] ADDR_WAKE_INT_CTRL = 7'h06;
    localparam logic [6:0] ADDR_WAKE_PULL = 7'h08;
    localparam logic [6:0] ADDR_WAKE_FILT = 7'h09;
    localparam logic [6:0] ADDR_TIMER_A = 7'h0c;

    // Writable bits per register; everything else is reserved
    localparam logic [7:0] MASK_WAKE_INT_CTRL = 8'h40;
    localparam logic [7:0] MASK_WAKE_PULL = 8'h3f;
    localparam logic [7:0] MASK_WAKE_FILT = 8'h3f;
    localparam logic [7:0] MASK_TIMER_A = 8'h77;

    // Reset values
    localparam logic [7:0] RST_WAKE_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_WAKE_PULL = 8'h00;
    localparam logic [7:0] RST_WAKE_FILT = 8'h00;
    localparam logic [7:0] RST_TIMER_A = 8'h00;

    // Field positions
    localparam int FLD_W = 2;
    localparam int TMR_ON_LSB = 4;
    localparam int TMR_PER_LSB = 0;
    localparam int WAKE_EN_BIT = 6;

    // Pull codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // Filter codes
    localparam logic [1:0] FLT_STATIC_A = 2'h0;
    localparam logic [1:0] FLT_STATIC_B = 2'h1;
    localparam logic [1:0] FLT_CYC_A = 2'h2;
    localparam logic [1:0] FLT_CYC_B = 2'h3;

    // On-time codes that stop the timer
    localparam logic [2:0] ON_OFF_LOW = 3'h0;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;

    // On-time in ticks; zero means the timer does not run
    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1: on_ticks = 15'(ON_T1_US / TICK_US);
            3'h2: on_ticks = 15'(ON_T2_US / TICK_US);
            3'h3: on_ticks = 15'(ON_T3_US / TICK_US);
            3'h4: on_ticks = 15'(ON_T4_US / TICK_US);
            3'h5: on_ticks = 15'(ON_T5_US / TICK_US);
            default: on_ticks = 15'h0;
        endcase
    endfunction : on_ticks

    // Period in ticks; zero marks the reserved code
    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0: per_ticks = 15'(PER_T0_MS * 1000 / TICK_US);
            3'h1: per_ticks = 15'(PER_T1_MS * 1000 / TICK_US);
            3'h2: per_ticks = 15'(PER_T2_MS * 1000 / TICK_US);
            3'h3: per_ticks = 15'(PER_T3_MS * 1000 / TICK_US);
            3'h4: per_ticks = 15'(PER_T4_MS * 1000 / TICK_US);
            3'h5: per_ticks = 15'(PER_T5_MS * 1000 / TICK_US);
            3'h6: per_ticks = 15'(PER_T6_MS * 1000 / TICK_US);
            default: per_ticks = 15'h0;
        endcase
    endfunction : per_ticks

endpackage : wct_pkg

// ==== hdl/wct_spi_port.sv ====
// Serial configuration port: 16-bit frames, address, write flag, data
`timescale 1ns/100ps
`default_nettype none
module wct_spi_port
    import wct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    // Register side
    output logic [wct_pkg::ADDR_BITS-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    import wct_pkg::*;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [2:0] mosi_s;
        logic sclk_f;
        logic cs_n_f;
        logic mosi_f;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic miso;
        logic wr;
    } wct_spi_state_t;

    wct_spi_state_t st_q, st_d;

    // Pins pass three flops; a level is taken once the second and third agree
    always_comb begin
        st_d = st_q;
        st_d.wr = 1'b0;
        st_d.sclk_s = {st_q.sclk_s[1:0], spi_sclk};
        st_d.cs_s = {st_q.cs_s[1:0], spi_cs_n};
        st_d.mosi_s = {st_q.mosi_s[1:0], spi_mosi};
        if (st_q.sclk_s[1] == st_q.sclk_s[2]) begin
            st_d.sclk_f = st_q.sclk_s[2];
        end
        if (st_q.cs_s[1] == st_q.cs_s[2]) begin
            st_d.cs_n_f = st_q.cs_s[2];
        end
        if (st_q.mosi_s[1] == st_q.mosi_s[2]) begin
            st_d.mosi_f = st_q.mosi_s[2];
        end
        if (st_q.cs_n_f) begin
            // Idle: a full frame with the write flag set commits on deselect
            if (st_q.cnt == 5'(FRAME_BITS) && st_q.rx[8]) begin
                st_d.wr = 1'b1;
            end
            st_d.cnt = 5'h0;
            st_d.miso = 1'b0;
        end else if (st_d.sclk_f && !st_q.sclk_f) begin
            // Rising edge samples data in, MSB first
            st_d.rx = {st_q.rx[14:0], st_q.mosi_f};
            if (st_q.cnt != 5'(FRAME_BITS)) begin
                st_d.cnt = st_q.cnt + 5'h1;
            end
            // Read data is loaded on the edge that samples the write flag, once the address is in
            if (st_q.cnt == 5'(ADDR_BITS)) begin
                st_d.tx = reg_rdata;
            end
        end else if (!st_d.sclk_f && st_q.sclk_f) begin
            // Falling edge presents the next read bit
            if (st_q.cnt >= 5'(ADDR_BITS + 1) && st_q.cnt < 5'(FRAME_BITS)) begin
                st_d.miso = st_q.tx[7];
                st_d.tx = {st_q.tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{sclk_s: 3'h0, cs_s: 3'h7, mosi_s: 3'h0, cs_n_f: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // The address is live during the frame so read data can be looked up;
    // the write strobe comes after the count is cleared, so it keeps the frame address
    assign reg_addr = (st_q.cnt == 5'(FRAME_BITS) || st_q.wr) ? st_q.rx[15:9] : st_q.rx[6:0];
    assign reg_wdata = st_q.rx[7:0];
    assign reg_wr = st_q.wr;
    assign spi_miso = st_q.miso;
    assign spi_miso_oe_n = st_q.cs_n_f;

endmodule : wct_spi_port
`default_nettype wire

// ==== hdl/wct_wake_timer.sv ====
// Wake input pull, filter and cyclic timer A logic with its register file
`timescale 1ns/100ps
`default_nettype none
module wct_wake_timer
    import wct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial configuration pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    // Chip state
    input wire logic soft_reset,
    input wire logic chip_restart_state,
    input wire logic hs_switch_cleared,
    input wire logic hs_timer_a_assigned,
    input wire logic cyc_timer_b_on_end,
    // Wake pins
    input wire logic wake_input_one,
    input wire logic wake_input_two,
    input wire logic wake_input_three,
    // Pull resistor controls, one bit per wake input
    output logic [2:0] wake_pull_down_en,
    output logic [2:0] wake_pull_up_en,
    output logic [2:0] wake_pull_auto_en,
    // Filtered wake levels and change pulses
    output logic [2:0] wake_level,
    output logic [2:0] wake_change,
    // Timer A
    output logic high_side_switch_output,
    output logic cyc_timer_a_on_end,
    output logic cyc_timer_a_wake
);
    import wct_pkg::*;

    typedef struct packed {
        // Registers
        logic cyc_timer_a_wake_enable;
        logic [5:0] pull_sel;
        logic [5:0] filter_sel;
        logic [2:0] cyc_timer_a_on_time;
        logic [2:0] cyc_timer_a_period;
        // Restart edge detect
        logic restart_seen;
        // Timer A
        logic [10:0] tick_cnt;
        logic [14:0] per_cnt;
        logic running;
        logic hs_out;
        logic on_end;
        logic wake_pulse;
        // Wake input conditioning
        logic [2:0][2:0] in_s;
        logic [2:0] in_agreed;
        logic [2:0][10:0] flt_cnt;
        logic [2:0] flt_val;
        logic [2:0] level;
        logic [2:0] change;
    } wct_state_t;

    wct_state_t st_q, st_d;

    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic [7:0] reg_rdata;
    logic [2:0] wake_pins;
    logic [14:0] on_len;
    logic [14:0] per_len;
    logic timer_go;
    logic tick;
    logic any_cyc;

    // Decode one pull code into {auto, up, down}
    function automatic logic [2:0] pull_decode(input logic [1:0] code);
        case (code)
            PULL_DOWN: pull_decode = 3'h1;
            PULL_UP: pull_decode = 3'h2;
            PULL_AUTO: pull_decode = 3'h4;
            default: pull_decode = 3'h0;
        endcase
    endfunction : pull_decode

    // Masked register write: reserved positions keep zero
    function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
        masked = data & mask;
    endfunction : masked

    // Serial port front end
    wct_spi_port u_spi (
        .clk(clk),
        .rst_n(rst_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rdata(reg_rdata)
    );

    assign wake_pins = {wake_input_three, wake_input_two, wake_input_one};

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        if (reg_addr == ADDR_WAKE_INT_CTRL) begin
            reg_rdata = masked(8'(st_q.cyc_timer_a_wake_enable) << WAKE_EN_BIT, MASK_WAKE_INT_CTRL);
        end else if (reg_addr == ADDR_WAKE_PULL) begin
            reg_rdata = {2'h0, st_q.pull_sel};
        end else if (reg_addr == ADDR_WAKE_FILT) begin
            reg_rdata = {2'h0, st_q.filter_sel};
        end else if (reg_addr == ADDR_TIMER_A) begin
            reg_rdata = {1'b0, st_q.cyc_timer_a_on_time, 1'b0, st_q.cyc_timer_a_period};
        end else begin
            reg_rdata = 8'h00;
        end
    end

    // Timer A decode; reserved codes give zero length and so never run
    assign on_len = on_ticks(st_q.cyc_timer_a_on_time);
    assign per_len = per_ticks(st_q.cyc_timer_a_period);
    assign timer_go = hs_timer_a_assigned && (on_len != 15'h0) && (per_len != 15'h0);
    assign tick = (st_q.tick_cnt == TICK_CYC - 11'h1);

    // Any input in a cyclic mode, timer A or timer B sampling, counts as cyclic sense in use
    always_comb begin
        any_cyc = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (st_q.filter_sel[i*FLD_W +: FLD_W] == FLT_CYC_A || st_q.filter_sel[i*FLD_W +: FLD_W] == FLT_CYC_B) begin
                any_cyc = 1'b1;
            end
        end
    end

    // Next-state logic for registers, timer and wake filters
    always_comb begin
        logic [10:0] limit;
        logic [1:0] fcode;
        logic sample;
        limit = FILT_A_CYC;
        fcode = FLT_STATIC_A;
        sample = 1'b0;
        st_d = st_q;
        st_d.on_end = 1'b0;
        st_d.wake_pulse = 1'b0;
        st_d.change = 3'h0;
        st_d.restart_seen = chip_restart_state;

        // Register writes; reserved bits are masked off
        if (reg_wr) begin
            if (reg_addr == ADDR_WAKE_INT_CTRL) begin
                st_d.cyc_timer_a_wake_enable = reg_wdata[WAKE_EN_BIT];
            end else if (reg_addr == ADDR_WAKE_PULL) begin
                st_d.pull_sel = 6'(masked(reg_wdata, MASK_WAKE_PULL));
            end else if (reg_addr == ADDR_WAKE_FILT) begin
                st_d.filter_sel = 6'(masked(reg_wdata, MASK_WAKE_FILT));
            end else if (reg_addr == ADDR_TIMER_A) begin
                st_d.cyc_timer_a_on_time = reg_wdata[TMR_ON_LSB +: 3];
                st_d.cyc_timer_a_period = reg_wdata[TMR_PER_LSB +: 3];
            end
        end

        // Restart: pull and filter keep their six bits since only those exist
        if (chip_restart_state && !st_q.restart_seen) begin
            st_d.pull_sel = st_q.pull_sel;
            st_d.filter_sel = st_q.filter_sel;
        end

        // Switch clear in restart with cyclic sense wipes timer settings
        if (chip_restart_state && hs_switch_cleared && any_cyc) begin
            st_d.cyc_timer_a_on_time = ON_OFF_LOW;
            st_d.cyc_timer_a_period = 3'h0;
        end

        // Soft reset returns every register to its reset value
        if (soft_reset) begin
            st_d.cyc_timer_a_wake_enable = RST_WAKE_INT_CTRL[WAKE_EN_BIT];
            st_d.pull_sel = RST_WAKE_PULL[5:0];
            st_d.filter_sel = RST_WAKE_FILT[5:0];
            st_d.cyc_timer_a_on_time = RST_TIMER_A[TMR_ON_LSB +: 3];
            st_d.cyc_timer_a_period = RST_TIMER_A[TMR_PER_LSB +: 3];
        end

        // Timer A: starts from zero each time it becomes runnable
        st_d.running = timer_go;
        if (!timer_go || !st_q.running) begin
            st_d.tick_cnt = 11'h0;
            st_d.per_cnt = 15'h0;
        end else if (tick) begin
            st_d.tick_cnt = 11'h0;
            if (st_q.per_cnt == on_len - 15'h1) begin
                st_d.on_end = 1'b1;
            end
            if (st_q.per_cnt >= per_len - 15'h1) begin
                st_d.per_cnt = 15'h0;
                st_d.wake_pulse = st_q.cyc_timer_a_wake_enable;
            end else begin
                st_d.per_cnt = st_q.per_cnt + 15'h1;
            end
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 11'h1;
        end

        // Switch drive: high while on, held levels when stopped
        if (st_q.cyc_timer_a_on_time == ON_OFF_HIGH) begin
            st_d.hs_out = 1'b1;
        end else if (st_d.running) begin
            st_d.hs_out = (st_d.per_cnt < on_len);
        end else begin
            st_d.hs_out = 1'b0;
        end

        // Wake inputs: three flops, agreement of the last two, then filter
        for (int i = 0; i < 3; i++) begin
            st_d.in_s[i] = {st_q.in_s[i][1:0], wake_pins[i]};
            if (st_q.in_s[i][1] == st_q.in_s[i][2]) begin
                st_d.in_agreed[i] = st_q.in_s[i][2];
            end
            fcode = st_q.filter_sel[i*FLD_W +: FLD_W];
            limit = (fcode == FLT_STATIC_B) ? FILT_B_CYC : FILT_A_CYC;
            if (st_q.in_agreed[i] != st_q.flt_val[i]) begin
                if (st_q.flt_cnt[i] >= limit - 11'h1) begin
                    st_d.flt_val[i] = st_q.in_agreed[i];
                    st_d.flt_cnt[i] = 11'h0;
                end else begin
                    st_d.flt_cnt[i] = st_q.flt_cnt[i] + 11'h1;
                end
            end else begin
                st_d.flt_cnt[i] = 11'h0;
            end
            // Cyclic modes only look at the filtered level at the on-end point
            case (fcode)
                FLT_CYC_A: sample = st_q.on_end;
                FLT_CYC_B: sample = cyc_timer_b_on_end;
                default: sample = 1'b1;
            endcase
            if (sample) begin
                st_d.level[i] = st_q.flt_val[i];
            end
            st_d.change[i] = (st_d.level[i] != st_q.level[i]);
        end
    end

    // State register; async reset clears all configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Pull controls decoded per input
    always_comb begin
        logic [2:0] dec;
        dec = 3'h0;
        for (int i = 0; i < 3; i++) begin
            dec = pull_decode(st_q.pull_sel[i*FLD_W +: FLD_W]);
            wake_pull_down_en[i] = dec[0];
            wake_pull_up_en[i] = dec[1];
            wake_pull_auto_en[i] = dec[2];
        end
    end

    // Registered outputs
    assign wake_level = st_q.level;
    assign wake_change = st_q.change;
    assign high_side_switch_output = st_q.hs_out;
    assign cyc_timer_a_on_end = st_q.on_end;
    assign cyc_timer_a_wake = st_q.wake_pulse;

endmodule : wct_wake_timer
`default_nettype wire

// ==== verification/wct_wake_timer_properties.sv ====
// Port-level checks on the wake input and cyclic timer block
`timescale 1ns/100ps
`default_nettype none
module wct_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs
    input wire logic soft_reset,
    input wire logic hs_timer_a_assigned,
    // Outputs
    input wire logic [2:0] wake_pull_down_en,
    input wire logic [2:0] wake_pull_up_en,
    input wire logic [2:0] wake_pull_auto_en,
    input wire logic [2:0] wake_level,
    input wire logic [2:0] wake_change,
    input wire logic high_side_switch_output,
    input wire logic cyc_timer_a_on_end,
    input wire logic cyc_timer_a_wake
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Three idle samples let a pulse already in flight drain first
    sequence s_unassigned;
        !hs_timer_a_assigned [*3];
    endsequence
    sequence s_soft_clear;
        soft_reset ##2 1'b1;
    endsequence
    a_pull_one_hot: assert property ((wake_pull_down_en & wake_pull_up_en) == 3'h0 &&
        (wake_pull_auto_en & (wake_pull_down_en | wake_pull_up_en)) == 3'h0) else $error("pull controls overlap");
    a_soft_clears_all: assert property (s_soft_clear |-> !high_side_switch_output &&
        (wake_pull_down_en | wake_pull_up_en | wake_pull_auto_en) == 3'h0) else $error("soft reset left state");
    a_on_end_single: assert property (cyc_timer_a_on_end |=> !cyc_timer_a_on_end)
        else $error("on-end pulse too long");
    a_on_end_after_high: assert property (cyc_timer_a_on_end |-> $past(high_side_switch_output, 2))
        else $error("on-end without on-time");
    a_wake_single: assert property (cyc_timer_a_wake |=> !cyc_timer_a_wake)
        else $error("wake pulse too long");
    a_idle_no_events: assert property (s_unassigned |-> !cyc_timer_a_on_end && !cyc_timer_a_wake)
        else $error("timer ran unassigned");
    a_change_marks_level: assert property (wake_change[0] |-> wake_level[0] != $past(wake_level[0]) ||
        $past(wake_level[0]) != $past(wake_level[0], 2)) else $error("change pulse without level change");
    a_level_has_pulse: assert property ($changed(wake_level[2]) |-> ##[0:1] wake_change[2])
        else $error("level changed silently");
endmodule : wct_checker
bind wct_wake_timer wct_checker wct_checker_i (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .hs_timer_a_assigned(hs_timer_a_assigned), .wake_pull_down_en(wake_pull_down_en),
    .wake_pull_up_en(wake_pull_up_en), .wake_pull_auto_en(wake_pull_auto_en), .wake_level(wake_level),
    .wake_change(wake_change), .high_side_switch_output(high_side_switch_output),
    .cyc_timer_a_on_end(cyc_timer_a_on_end), .cyc_timer_a_wake(cyc_timer_a_wake));
`default_nettype wire

// ==== verification/wct_wake_timer_tb.sv ====
// Self-checking bench for the wake input and cyclic timer block
`timescale 1ns/100ps
`default_nettype none
module wct_wake_timer_tb;
    import wct_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0, soft_rst = 1'b0;
    logic restart = 1'b0, hs_clr = 1'b0, assigned = 1'b0, b_end = 1'b0;
    logic [2:0] wk = 3'h0;
    logic miso, miso_oe_n, hs_out, a_end, a_wake;
    logic [2:0] pd, pu, pa, lvl, chg;
    logic [7:0] rd;
    logic [6:0] regs [4] = '{7'h06, 7'h08, 7'h09, 7'h0c};
    logic [7:0] wmask [4] = '{8'h40, 8'h3f, 8'h3f, 8'h77};
    int errors = 0, n_compared = 0, cycles = 0, cnt = 0, n_end = 0, ends0 = 0, n_chg = 0, chg0 = 0, n_wake = 0;
    always #25 clk = ~clk;
    wct_wake_timer wct_wake_timer_i (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .soft_reset(soft_rst),
        .chip_restart_state(restart), .hs_switch_cleared(hs_clr), .hs_timer_a_assigned(assigned),
        .cyc_timer_b_on_end(b_end), .wake_input_one(wk[0]), .wake_input_two(wk[1]), .wake_input_three(wk[2]),
        .wake_pull_down_en(pd), .wake_pull_up_en(pu), .wake_pull_auto_en(pa), .wake_level(lvl),
        .wake_change(chg), .high_side_switch_output(hs_out), .cyc_timer_a_on_end(a_end),
        .cyc_timer_a_wake(a_wake));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    // One frame; slow serial clock so the three-flop synchroniser never misses an edge
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
        logic [15:0] f;
        f = {a, w, d};
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            tick(6);
            sclk = 1'b1;
            if (i < 8) rd[i] = miso;
            tick(6);
            sclk = 1'b0;
        end
        tick(6);
        cs_n = 1'b1;
        tick(8);
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        chk(rd, exp);
    endtask : rd_chk
    task automatic restart_pulse(input logic clr);
        restart = 1'b1;
        hs_clr = clr;
        tick(4);
        restart = 1'b0;
        hs_clr = 1'b0;
        tick(2);
    endtask : restart_pulse
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    // Count on-end pulses; hang guard well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (a_end === 1'b1) n_end++;
        if (chg[0] === 1'b1) n_chg++;
        if (a_wake === 1'b1) n_wake++;
        if (cycles == 40000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        tick(3);
        rst_n = 1'b1;
        tick(4);
        chk(miso_oe_n, 1'b1);
        // Reset values, unmapped address, reserved bits
        for (int k = 0; k < 4; k++) rd_chk(regs[k], 8'h00);
        rd_chk(7'h3f, 8'h00);
        assigned = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(regs[k], 8'hff);
            rd_chk(regs[k], wmask[k]);
        end
        chk(hs_out, 1'b0);
        // Every pull code in every field position
        for (int f = 0; f < 3; f++) begin
            for (int c = 0; c < 4; c++) begin
                logic [2:0] e;
                e = 3'(1 << f);
                wr(7'h08, 8'(c << (2 * f)));
                chk({pd, pu, pa}, {c == 1 ? e : 3'h0, c == 2 ? e : 3'h0, c == 3 ? e : 3'h0});
            end
        end
        // Input three sampled only at the timer A on-time end
        wr(7'h09, 8'h20);
        wk = 3'h4;
        tick(400);
        chk(lvl[2], 1'b0);
        wr(7'h0c, 8'h60);
        chk(hs_out, 1'b1);
        wr(7'h0c, 8'h00);
        chk(hs_out, 1'b0);
        assigned = 1'b0;
        wr(7'h0c, 8'h10);
        tick(50);
        chk(hs_out, 1'b0);
        assigned = 1'b1;
        tick(5);
        chk(hs_out, 1'b1);
        // Measured on-times of 0.1 ms and 0.3 ms at 50 ns per cycle
        for (int c = 1; c < 3; c++) begin
            wr(7'h0c, 8'h00);
            ends0 = n_end;
            wr(7'h0c, 8'(c << 4));
            // The output has been high for one cycle when the write returns
            cnt = 1;
            while (hs_out === 1'b1 && cnt < 9000) begin
                tick(1);
                cnt++;
            end
            tick(3);
            chk(cnt >= (c == 1 ? 1980 : 5980) && cnt <= (c == 1 ? 2020 : 6020), 1'b1);
            chk(n_end - ends0, 1);
            chk(lvl[2], 1'b1);
        end
        // Restart keeps the wake settings; timer cleared only with cyclic sensing and switch clear
        wr(7'h08, 8'h2a);
        wr(7'h09, 8'h15);
        wr(7'h0c, 8'h13);
        restart_pulse(1'b1);
        rd_chk(7'h0c, 8'h13);
        wr(7'h09, 8'h2a);
        restart_pulse(1'b0);
        rd_chk(7'h0c, 8'h13);
        restart_pulse(1'b1);
        rd_chk(7'h08, 8'h2a);
        rd_chk(7'h09, 8'h2a);
        rd_chk(7'h0c, 8'h00);
        // Static filters: 320 and 1280 cycles of steady input
        chg0 = n_chg;
        wr(7'h09, 8'h00);
        wk = 3'h1;
        tick(250);
        chk(lvl[0], 1'b0);
        tick(150);
        chk(lvl[0], 1'b1);
        wr(7'h09, 8'h01);
        wk = 3'h0;
        tick(1100);
        chk(lvl[0], 1'b1);
        tick(300);
        chk(lvl[0], 1'b0);
        chk(n_chg - chg0, 2);
        // Input two sampled on the timer B on-time end
        wr(7'h09, 8'h0c);
        wk = 3'h2;
        tick(400);
        chk(lvl[1], 1'b0);
        b_end = 1'b1;
        tick(1);
        b_end = 1'b0;
        tick(3);
        chk(lvl[1], 1'b1);
        // Soft reset clears every register
        wr(7'h08, 8'h2a);
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        tick(2);
        chk(pu, 3'h0);
        for (int k = 0; k < 4; k++) rd_chk(regs[k], 8'h00);
        // The shortest period is far longer than this run, so no wrap may have happened
        chk(n_wake, 0);
        print_verdict();
    end
endmodule : wct_wake_timer_tb
`default_nettype wire
